// *** pci_win_pkg.sv ***
// package: register map, field layout, reset values and state record of the target window
package pci_win_pkg;
  // register byte offsets on the apb port
  localparam logic [11:0] CTL_OFS = 12'h500; // target_window_control
  localparam logic [11:0] XLAT_OFS = 12'h504; // target_window_translation
  localparam logic [11:0] BASE_OFS = 12'h600; // window_base_register
  localparam logic [11:0] SHELL_OFS = 12'h604; // message_shell_enable holder

  // control, translation and shell register field positions
  localparam int IMAGE_DECODE_ENABLE_BIT = 31;
  localparam int XLAT_EN_BIT = 30;
  localparam int BAR_EN_BIT = 29;
  localparam int SIZE_LSB = 24;
  localparam int RTYPE_LSB = 16;
  localparam int GLOBAL_BIT = 15;
  localparam int INHIBIT_BIT = 14;
  localparam int WTYPE_LSB = 8;
  localparam int RETAIN_BIT = 7;
  localparam int ORDER_LSB = 4;
  localparam int ALIAS_BIT = 3;
  localparam int PFLEN_LSB = 0;
  localparam int TRANSLATED_UPPER_ADDR_LSB = 16; // translation field, also base field position
  localparam int SHELL_EN_BIT = 0;

  // reset values
  localparam logic [4:0] RTYPE_RST = 5'h0a; // read
  localparam logic [4:0] WTYPE_RST = 5'h02; // write with flush
  localparam logic [1:0] ORDER_RST = 2'h2; // big-endian
  localparam logic [3:0] SIZE_RST = 4'h0;
  localparam logic [15:0] TRANSLATED_UPPER_ADDR_RST = 16'h0000;

  // window geometry
  localparam int WIN_MIN_BITS = 16; // 64 KB smallest window
  localparam int SHELL_BITS = 12; // lowest 4 KB is the message shell
  localparam logic [7:0] PF_SHELL_BYTES = 8'h08; // fixed fetch for shell and plain reads
  localparam logic [31:0] DWORD_STEP = 32'h0000_0004;

  // all state of the top module
  typedef struct packed {
    logic image_en;
    logic xlat_en;
    logic bar_en;
    logic [3:0] size_code;
    logic [4:0] read_type;
    logic global_ctl;
    logic inhibit_ctl;
    logic [4:0] write_type;
    logic retain_en;
    logic [1:0] byte_order;
    logic alias_en;
    logic [2:0] pf_code;
    logic [15:0] translated_upper_addr;
    logic [15:0] base;
    logic base_written;
    logic shell_en;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic claim;
    logic retry;
    logic lb_req;
    logic lb_write;
    logic [31:0] lb_addr;
    logic [4:0] lb_type;
    logic glob_n;
    logic inh_n;
    logic [7:0] pf_bytes;
    logic [1:0] lb_order;
    logic lb_retained;
    logic lb_shell;
    logic ret_valid;
    logic [31:0] ret_next;
    logic [31:0] ret_end;
  } win_state_t;
endpackage : pci_win_pkg

// *** win_dec_if.sv ***
// interface: window decode request and result between control and decoder
`timescale 1ns/1ps
`default_nettype none
interface win_dec_if;
  logic [31:0] addr; // incoming pci address
  logic [15:0] base; // window base, upper half
  logic [3:0] size_code; // window size code
  logic xlat_en; // substitution on
  logic [15:0] translated_upper_addr; // substitute upper bits
  logic hit; // address inside window
  logic shell; // inside lowest 4 KB of window
  logic [31:0] xaddr; // address as sent to the local bus
  logic [15:0] mask; // compared upper bits

  modport cfg (output addr, base, size_code, xlat_en, translated_upper_addr, input hit, shell, xaddr, mask);
  modport dec (input addr, base, size_code, xlat_en, translated_upper_addr, output hit, shell, xaddr, mask);
endinterface : win_dec_if
`default_nettype wire

// *** win_decode.sv ***
// module: combinational window compare, shell detect and upper address substitution
`timescale 1ns/1ps
`default_nettype none
module win_decode (
  // decode channel
  win_dec_if.dec d
);
  // mask of compared bits 31 down to 16 plus size code
  always_comb begin
    d.mask = 16'hffff << d.size_code;
    d.hit = ((d.addr[31:16] ^ d.base) & d.mask) == 16'h0000;
    // offset inside window below 4 KB is the shell area
    d.shell = ((d.addr[31:16] & ~d.mask) == 16'h0000) &&
              (d.addr[15:pci_win_pkg::SHELL_BITS] == 4'h0);
    // substitution replaces only the compared bits
    if (d.xlat_en) begin
      d.xaddr = {(d.addr[31:16] & ~d.mask) | (d.translated_upper_addr & d.mask), d.addr[15:0]};
    end else begin
      d.xaddr = d.addr;
    end
  end
endmodule : win_decode
`default_nettype wire

// *** pci_target_window_ctl.sv ***
// module: pci target window control with apb register file and local bus request
`timescale 1ns/1ps
`default_nettype none
module pci_target_window_ctl (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_srst,
  // eeprom strap values, used during reset
  input wire logic i_eeprom_load,
  input wire logic i_eeprom_bar_en,
  input wire logic [3:0] i_eeprom_size_code,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // pci memory request, one-cycle pulse
  input wire logic i_pci_req,
  input wire logic [31:0] i_pci_addr,
  input wire logic i_pci_write,
  input wire logic i_pci_read_multiple,
  output logic o_pci_claim,
  output logic o_pci_retry,
  // local bus request
  output logic o_lb_req,
  output logic o_lb_write,
  output logic [31:0] o_lb_addr,
  output logic [4:0] o_local_bus_xfer_type,
  output logic o_local_global_n,
  output logic o_local_inhibit_n,
  output logic [7:0] o_lb_prefetch_bytes,
  output logic [1:0] o_lb_byte_order,
  output logic o_lb_retained,
  output logic o_lb_shell
);
  pci_win_pkg::win_state_t s_r; // registered state
  pci_win_pkg::win_state_t s_nxt; // next state
  win_dec_if dec_if ();
  logic apb_first; // first access cycle, answer being prepared
  logic apb_done; // completion edge, write takes effect
  logic [31:0] ctl_word; // assembled control register
  logic [31:0] base_word; // visible base register
  logic [15:0] base_wr; // written base after size masking
  logic win_sel; // request decoded by the window
  logic rd_hit; // read served from retained data
  logic [7:0] pf_amt; // read prefetch amount, programmed only for read multiple or alias, else 8 bytes

  // prefetch code to bytes; reserved codes fall back to the smallest fetch
  function automatic logic [7:0] pf_bytes_of(input logic [2:0] code);
    logic [7:0] b;
    b = pci_win_pkg::PF_SHELL_BYTES;
    if (code <= 3'h4) begin
      b = pci_win_pkg::PF_SHELL_BYTES << code;
    end
    return b;
  endfunction : pf_bytes_of

  // decoder is fed straight from stored settings
  assign dec_if.addr = i_pci_addr;
  assign dec_if.base = s_r.base;
  assign dec_if.size_code = s_r.size_code;
  assign dec_if.xlat_en = s_r.xlat_en;
  assign dec_if.translated_upper_addr = s_r.translated_upper_addr;

  win_decode u_dec (
    .d (dec_if.dec)
  );

  // register views and request qualifiers
  always_comb begin
    ctl_word = 32'h0000_0000;
    ctl_word[pci_win_pkg::IMAGE_DECODE_ENABLE_BIT] = s_r.image_en;
    ctl_word[pci_win_pkg::XLAT_EN_BIT] = s_r.xlat_en;
    ctl_word[pci_win_pkg::BAR_EN_BIT] = s_r.bar_en;
    ctl_word[pci_win_pkg::SIZE_LSB +: 4] = s_r.size_code;
    ctl_word[pci_win_pkg::RTYPE_LSB +: 5] = s_r.read_type;
    ctl_word[pci_win_pkg::GLOBAL_BIT] = s_r.global_ctl;
    ctl_word[pci_win_pkg::INHIBIT_BIT] = s_r.inhibit_ctl;
    ctl_word[pci_win_pkg::WTYPE_LSB +: 5] = s_r.write_type;
    ctl_word[pci_win_pkg::RETAIN_BIT] = s_r.retain_en;
    ctl_word[pci_win_pkg::ORDER_LSB +: 2] = s_r.byte_order;
    ctl_word[pci_win_pkg::ALIAS_BIT] = s_r.alias_en;
    ctl_word[pci_win_pkg::PFLEN_LSB +: 3] = s_r.pf_code;
    // hidden base reads as zero
    base_word = s_r.bar_en ? {s_r.base, 16'h0000} : 32'h0000_0000;
    // bits below the window size stay zero, as a sizing probe expects
    base_wr = i_pwdata[pci_win_pkg::TRANSLATED_UPPER_ADDR_LSB +: 16] & dec_if.mask;
    apb_first = i_psel && i_penable && !s_r.pready;
    apb_done = i_psel && i_penable && s_r.pready;
    win_sel = i_pci_req && s_r.image_en && s_r.bar_en && dec_if.hit;
    pf_amt = (i_pci_read_multiple || s_r.alias_en) ?
             pf_bytes_of(s_r.pf_code) : pci_win_pkg::PF_SHELL_BYTES;
    // sequential read inside what was fetched before
    rd_hit = !i_pci_write && !dec_if.shell && s_r.retain_en && s_r.ret_valid &&
             (i_pci_addr == s_r.ret_next) && (i_pci_addr < s_r.ret_end);
  end

  // next state: apb slave, control writes and request forwarding
  always_comb begin
    s_nxt = s_r;
    // pulses last one cycle
    s_nxt.claim = 1'b0;
    s_nxt.retry = 1'b0;
    s_nxt.lb_req = 1'b0;
    s_nxt.lb_retained = 1'b0;
    s_nxt.pready = 1'b0;
    s_nxt.pslverr = 1'b0;
    // answer is built one cycle into the access phase
    if (apb_first) begin
      s_nxt.pready = 1'b1;
      s_nxt.prdata = 32'h0000_0000;
      case (i_paddr)
        pci_win_pkg::CTL_OFS: begin
          s_nxt.prdata = ctl_word;
        end
        pci_win_pkg::XLAT_OFS: begin
          s_nxt.prdata = {s_r.translated_upper_addr, 16'h0000};
        end
        pci_win_pkg::BASE_OFS: begin
          s_nxt.prdata = base_word;
        end
        pci_win_pkg::SHELL_OFS: begin
          s_nxt.prdata = {31'h0000_0000, s_r.shell_en};
        end
        default: begin
          s_nxt.pslverr = 1'b1; // unmapped address
        end
      endcase
    end
    // writes land at the edge the master samples pready
    if (apb_done && i_pwrite) begin
      case (i_paddr)
        pci_win_pkg::CTL_OFS: begin
          s_nxt.image_en = i_pwdata[pci_win_pkg::IMAGE_DECODE_ENABLE_BIT];
          s_nxt.xlat_en = i_pwdata[pci_win_pkg::XLAT_EN_BIT];
          s_nxt.bar_en = i_pwdata[pci_win_pkg::BAR_EN_BIT];
          s_nxt.size_code = i_pwdata[pci_win_pkg::SIZE_LSB +: 4];
          s_nxt.read_type = i_pwdata[pci_win_pkg::RTYPE_LSB +: 5];
          s_nxt.global_ctl = i_pwdata[pci_win_pkg::GLOBAL_BIT];
          s_nxt.inhibit_ctl = i_pwdata[pci_win_pkg::INHIBIT_BIT];
          s_nxt.write_type = i_pwdata[pci_win_pkg::WTYPE_LSB +: 5];
          s_nxt.retain_en = i_pwdata[pci_win_pkg::RETAIN_BIT];
          s_nxt.byte_order = i_pwdata[pci_win_pkg::ORDER_LSB +: 2];
          s_nxt.alias_en = i_pwdata[pci_win_pkg::ALIAS_BIT];
          s_nxt.pf_code = i_pwdata[pci_win_pkg::PFLEN_LSB +: 3];
        end
        pci_win_pkg::XLAT_OFS: begin
          s_nxt.translated_upper_addr = i_pwdata[pci_win_pkg::TRANSLATED_UPPER_ADDR_LSB +: 16];
        end
        pci_win_pkg::BASE_OFS: begin
          // frozen while hidden
          if (s_r.bar_en) begin
            s_nxt.base = base_wr;
            s_nxt.base_written = 1'b1;
            if (base_wr == 16'h0000) begin
              s_nxt.image_en = 1'b0;
            end else if (!s_r.base_written) begin
              s_nxt.image_en = 1'b1;
            end
          end
        end
        pci_win_pkg::SHELL_OFS: begin
          s_nxt.shell_en = i_pwdata[pci_win_pkg::SHELL_EN_BIT];
        end
        default: begin
          s_nxt.prdata = s_r.prdata; // unmapped write is dropped
        end
      endcase
    end
    // pci side: retry while shell is off, else claim and forward
    if (win_sel) begin
      if (!s_r.shell_en) begin
        s_nxt.retry = 1'b1;
      end else begin
        s_nxt.claim = 1'b1;
        s_nxt.lb_write = i_pci_write;
        s_nxt.lb_shell = dec_if.shell;
        s_nxt.lb_type = i_pci_write ? s_r.write_type : s_r.read_type;
        s_nxt.glob_n = s_r.global_ctl;
        s_nxt.inh_n = s_r.inhibit_ctl;
        if (dec_if.shell) begin
          // shell path uses raw address, fixed fetch size and byte order
          s_nxt.lb_addr = i_pci_addr;
          s_nxt.pf_bytes = pci_win_pkg::PF_SHELL_BYTES;
          s_nxt.lb_order = pci_win_pkg::ORDER_RST;
        end else begin
          s_nxt.lb_addr = dec_if.xaddr;
          s_nxt.pf_bytes = i_pci_write ? pci_win_pkg::PF_SHELL_BYTES : pf_amt;
          s_nxt.lb_order = s_r.byte_order;
        end
        if (rd_hit) begin
          // no new fetch; retained data answers
          s_nxt.lb_retained = 1'b1;
          s_nxt.ret_next = s_r.ret_next + pci_win_pkg::DWORD_STEP;
        end else begin
          s_nxt.lb_req = 1'b1;
          if (!i_pci_write) begin
            // any other read discards what was kept
            s_nxt.ret_valid = s_r.retain_en && !dec_if.shell;
            s_nxt.ret_next = i_pci_addr + pci_win_pkg::DWORD_STEP;
            s_nxt.ret_end = i_pci_addr + {24'h00_0000, pf_amt};
          end
        end
      end
    end
    // reset values, eeprom straps caught while reset is held
    if (i_srst) begin
      s_nxt = '0;
      s_nxt.bar_en = i_eeprom_load ? i_eeprom_bar_en : 1'b0;
      s_nxt.size_code = i_eeprom_load ? i_eeprom_size_code : pci_win_pkg::SIZE_RST;
      s_nxt.read_type = pci_win_pkg::RTYPE_RST;
      s_nxt.write_type = pci_win_pkg::WTYPE_RST;
      s_nxt.byte_order = pci_win_pkg::ORDER_RST;
      s_nxt.translated_upper_addr = pci_win_pkg::TRANSLATED_UPPER_ADDR_RST;
      s_nxt.lb_type = pci_win_pkg::RTYPE_RST;
      s_nxt.lb_order = pci_win_pkg::ORDER_RST;
      s_nxt.pf_bytes = pci_win_pkg::PF_SHELL_BYTES;
    end
  end

  // single state register; reset is folded into the next-state logic
  always_ff @(posedge i_sys_clk) begin
    s_r <= s_nxt;
  end

  // outputs come straight from the state register
  assign o_prdata = s_r.prdata;
  assign o_pready = s_r.pready;
  assign o_pslverr = s_r.pslverr;
  assign o_pci_claim = s_r.claim;
  assign o_pci_retry = s_r.retry;
  assign o_lb_req = s_r.lb_req;
  assign o_lb_write = s_r.lb_write;
  assign o_lb_addr = s_r.lb_addr;
  assign o_local_bus_xfer_type = s_r.lb_type;
  assign o_local_global_n = s_r.glob_n;
  assign o_local_inhibit_n = s_r.inh_n;
  assign o_lb_prefetch_bytes = s_r.pf_bytes;
  assign o_lb_byte_order = s_r.lb_order;
  assign o_lb_retained = s_r.lb_retained;
  assign o_lb_shell = s_r.lb_shell;

  // one clock domain, so all checks share the clock and the reset
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);

  // checks beside the logic they guard
  // outputs lag the request by one edge, so settings are seen through $past
  // decode gating: nothing leaves the window unless both enables were set
  a_decode_gate: assert property (o_pci_claim |-> $past(s_r.image_en && s_r.bar_en))
    else $error("claim without both decode enables");
  // a miss or a closed window must stay silent, not even a retry
  a_miss_silent: assert property (
    (i_pci_req && !(s_r.image_en && s_r.bar_en && dec_if.hit))
    |=> !o_pci_claim && !o_pci_retry)
    else $error("request outside the open window was answered");
  a_retry_shell_off: assert property (
    (i_pci_req && s_r.image_en && s_r.bar_en && dec_if.hit && !s_r.shell_en)
    |=> o_pci_retry && !o_pci_claim)
    else $error("window access not retried while shell disabled");

  // forwarding: each claim is a new local request or a retained hit, never both
  a_claim_forward: assert property (o_pci_claim |-> (o_lb_req ^ o_lb_retained))
    else $error("claimed access not forwarded");
  // retained data only ever answers reads
  a_retain_hit: assert property (o_lb_retained |-> o_pci_claim && !o_lb_write)
    else $error("retained data served outside a claimed read");

  // transfer type and attributes copy the control fields of the request cycle
  a_read_type: assert property (
    o_lb_req && !o_lb_write |-> o_local_bus_xfer_type == $past(s_r.read_type))
    else $error("read transfer type wrong");
  a_write_type: assert property (
    o_lb_req && o_lb_write |-> o_local_bus_xfer_type == $past(s_r.write_type))
    else $error("write transfer type wrong");
  a_attr_levels: assert property (o_pci_claim |->
    (o_local_global_n == $past(s_r.global_ctl)) &&
    (o_local_inhibit_n == $past(s_r.inhibit_ctl)))
    else $error("attribute levels do not follow control bits");

  // shell accesses ignore the programmed fetch size and byte order
  a_shell_fixed: assert property (
    o_lb_req && o_lb_shell |-> o_lb_prefetch_bytes == 8'h08 && o_lb_byte_order == 2'h2)
    else $error("shell access used programmed settings");
  // shell addresses go out raw, and are never served from kept data
  a_shell_raw_addr: assert property (
    o_pci_claim && o_lb_shell |-> o_lb_addr == $past(i_pci_addr) && !o_lb_retained)
    else $error("shell access translated or served from retained data");

  // frame accesses: address, order and fetch size follow the settings
  a_xlat_off: assert property (
    o_pci_claim && !o_lb_shell && !$past(s_r.xlat_en) |-> o_lb_addr == $past(i_pci_addr))
    else $error("address changed with translation off");
  a_order_follow: assert property (
    o_pci_claim && !o_lb_shell |-> o_lb_byte_order == $past(s_r.byte_order))
    else $error("byte order does not follow control field");
  // reserved codes must still land on a legal amount
  a_fetch_sizes: assert property (
    o_lb_req && !o_lb_write |-> o_lb_prefetch_bytes inside {8'h08, 8'h10, 8'h20, 8'h40, 8'h80})
    else $error("prefetch amount outside the legal set");
  // a plain read without aliasing fetches the minimum
  a_plain_read: assert property (
    o_lb_req && !o_lb_write && !$past(s_r.alias_en || i_pci_read_multiple)
    |-> o_lb_prefetch_bytes == 8'h08)
    else $error("plain memory read fetched more than 8 bytes");

  // apb answer: one wait state, error only with zero data
  a_base_hidden: assert property (
    (apb_first && !i_pwrite && i_paddr == pci_win_pkg::BASE_OFS && !s_r.bar_en)
    |=> o_pready && o_prdata == 32'h0000_0000)
    else $error("hidden base register read not zero");
  a_apb_answer: assert property ($rose(i_psel && i_penable) |=> o_pready ##1 !o_pready)
    else $error("apb answer not one cycle into access");
  a_apb_error: assert property (o_pslverr |-> o_pready && o_prdata == 32'h0000_0000)
    else $error("error answer without zero data");
endmodule : pci_target_window_ctl
`default_nettype wire

// *** pci_master_model.sv ***
// partner: pci master that presents one memory request per bench trigger
`timescale 1ns/1ps
`default_nettype none
module pci_master_model (
  // clock
  input wire logic i_sys_clk,
  // trigger from the bench
  input wire logic i_go,
  input wire logic [31:0] i_addr,
  input wire logic i_write,
  input wire logic i_mult,
  // request lines towards the window
  output logic o_req,
  output logic [31:0] o_addr,
  output logic o_write,
  output logic o_mult
);
  // idle lines start low
  initial begin
    o_req = 1'h0;
    o_addr = 32'h0;
    o_write = 1'h0;
    o_mult = 1'h0;
  end
  // one-cycle request; outside it the lines toggle so no stale value can pass for a match
  always @(posedge i_sys_clk) begin
    o_req <= i_go;
    o_addr <= i_go ? i_addr : ~o_addr;
    o_write <= i_go ? i_write : ~o_write;
    o_mult <= i_go ? i_mult : ~o_mult;
  end
endmodule : pci_master_model
`default_nettype wire

// *** tb_top.sv ***
// testbench: apb register access and pci window decode of the target window
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // one table row: control word, request, expected local bus view
  typedef struct packed {
    logic [31:0] ctl;
    logic [31:0] addr;
    logic [2:0] cmd; // write, multiple, claim expected
    logic [31:0] xa;
    logic [4:0] tt;
    logic [7:0] pf;
    logic [1:0] ord;
    logic [2:0] att; // global_n, inhibit_n, shell
  } row_t;
  localparam int NROW = 19;
  row_t rows [NROW];
  logic i_sys_clk, i_srst, i_eeprom_load, i_eeprom_bar_en;
  logic [3:0] i_eeprom_size_code;
  logic i_psel, i_penable, i_pwrite, o_pready, o_pslverr;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata, i_pci_addr, o_lb_addr, go_addr;
  logic i_pci_req, i_pci_write, i_pci_read_multiple, o_pci_claim, o_pci_retry;
  logic o_lb_req, o_lb_write, o_local_global_n, o_local_inhibit_n, o_lb_retained, o_lb_shell;
  logic [4:0] o_local_bus_xfer_type;
  logic [7:0] o_lb_prefetch_bytes;
  logic [1:0] o_lb_byte_order;
  logic go, go_wr, go_mult;
  int fails, comparisons;
  int cyc = 0; // clock cycles since start, watchdog only

  pci_target_window_ctl DUT (.i_sys_clk, .i_srst, .i_eeprom_load, .i_eeprom_bar_en,
    .i_eeprom_size_code, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata,
    .o_pready, .o_pslverr, .i_pci_req, .i_pci_addr, .i_pci_write, .i_pci_read_multiple,
    .o_pci_claim, .o_pci_retry, .o_lb_req, .o_lb_write, .o_lb_addr, .o_local_bus_xfer_type,
    .o_local_global_n, .o_local_inhibit_n, .o_lb_prefetch_bytes, .o_lb_byte_order,
    .o_lb_retained, .o_lb_shell);
  pci_master_model pm (.i_sys_clk, .i_go(go), .i_addr(go_addr), .i_write(go_wr),
    .i_mult(go_mult), .o_req(i_pci_req), .o_addr(i_pci_addr), .o_write(i_pci_write),
    .o_mult(i_pci_read_multiple));

  // clock, 4 ns period
  initial begin
    i_sys_clk = 1'h0;
    forever #2 i_sys_clk = ~i_sys_clk;
  end
  // watchdog: the whole run needs well under a thousand cycles
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      finish_test();
    end
  end

  // verdict and end of run
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test
  // single comparison point
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // reset held two edges; requests start one edge after release
  task automatic rst();
    @(posedge i_sys_clk);
    i_srst <= 1'h1;
    repeat (2) @(posedge i_sys_clk);
    i_srst <= 1'h0;
    @(posedge i_sys_clk);
  endtask : rst
  // one apb transfer; waits for pready, only the watchdog ends a hung wait
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge i_sys_clk);
    i_psel <= 1'h1;
    i_penable <= 1'h0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_sys_clk);
    i_penable <= 1'h1;
    do begin
      @(posedge i_sys_clk);
    end while (o_pready !== 1'h1);
    q = o_prdata;
    e = o_pslverr;
    i_psel <= 1'h0;
    i_penable <= 1'h0;
  endtask : apb
  // register write, response ignored
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'h1, a, d, q, e);
  endtask : wr
  // register read against an expected word
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    logic [31:0] q;
    logic e;
    apb(1'h0, a, 32'h0, q, e);
    chk(q, x);
  endtask : rd
  // one pci request through the partner; returns once the answer has landed
  task automatic pci(input logic [31:0] a, input logic w, input logic m);
    @(posedge i_sys_clk);
    go <= 1'h1;
    go_addr <= a;
    go_wr <= w;
    go_mult <= m;
    @(posedge i_sys_clk);
    go <= 1'h0;
    @(posedge i_sys_clk);
    #1;
  endtask : pci

  // main sequence
  initial begin
    logic [31:0] q;
    logic e;
    {i_srst, i_eeprom_load, i_eeprom_bar_en, i_eeprom_size_code} = 7'h73;
    {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} = 47'h0;
    {go, go_wr, go_mult, go_addr} = 35'h0;
    fails = 0;
    comparisons = 0;
    rows = '{
      '{32'ha00a_0220, 32'h1234_1000, 3'h3, 32'h1234_1000, 5'h0a, 8'h08, 2'h2, 3'h0},
      '{32'ha00a_0220, 32'h1234_1100, 3'h5, 32'h1234_1100, 5'h02, 8'h08, 2'h2, 3'h0},
      '{32'ha00a_0220, 32'h1235_1000, 3'h2, 32'h0, 5'h0, 8'h0, 2'h0, 3'h0},
      '{32'he00a_0220, 32'h1234_1200, 3'h3, 32'habcd_1200, 5'h0a, 8'h08, 2'h2, 3'h0},
      '{32'he40a_0220, 32'h1238_1000, 3'h3, 32'habc8_1000, 5'h0a, 8'h08, 2'h2, 3'h0},
      '{32'hef0a_0220, 32'h7fff_1000, 3'h3, 32'hffff_1000, 5'h0a, 8'h08, 2'h2, 3'h0},
      '{32'he00a_02b4, 32'h1234_0010, 3'h3, 32'h1234_0010, 5'h0a, 8'h08, 2'h2, 3'h1},
      '{32'ha00a_0221, 32'h1234_1300, 3'h3, 32'h1234_1300, 5'h0a, 8'h10, 2'h2, 3'h0},
      '{32'ha00a_0222, 32'h1234_1400, 3'h3, 32'h1234_1400, 5'h0a, 8'h20, 2'h2, 3'h0},
      '{32'ha00a_0223, 32'h1234_1500, 3'h3, 32'h1234_1500, 5'h0a, 8'h40, 2'h2, 3'h0},
      '{32'ha00a_0224, 32'h1234_1600, 3'h3, 32'h1234_1600, 5'h0a, 8'h80, 2'h2, 3'h0},
      '{32'ha00a_0225, 32'h1234_1700, 3'h3, 32'h1234_1700, 5'h0a, 8'h08, 2'h2, 3'h0},
      '{32'ha00a_022b, 32'h1234_1800, 3'h1, 32'h1234_1800, 5'h0a, 8'h40, 2'h2, 3'h0},
      '{32'ha00a_0223, 32'h1234_1900, 3'h1, 32'h1234_1900, 5'h0a, 8'h08, 2'h2, 3'h0},
      '{32'ha00a_0200, 32'h1234_1a00, 3'h3, 32'h1234_1a00, 5'h0a, 8'h08, 2'h0, 3'h0},
      '{32'ha00a_0210, 32'h1234_1b00, 3'h3, 32'h1234_1b00, 5'h0a, 8'h08, 2'h1, 3'h0},
      '{32'ha00a_0230, 32'h1234_1c00, 3'h3, 32'h1234_1c00, 5'h0a, 8'h08, 2'h3, 3'h0},
      '{32'ha00a_c220, 32'h1234_1d00, 3'h3, 32'h1234_1d00, 5'h0a, 8'h08, 2'h2, 3'h6},
      '{32'ha00a_8220, 32'h1234_1e00, 3'h3, 32'h1234_1e00, 5'h0a, 8'h08, 2'h2, 3'h4}
    };
    // reset with strap load, then reset values
    rst();
    chk({o_local_bus_xfer_type, o_lb_prefetch_bytes, o_lb_byte_order}, 15'h2822);
    chk({o_local_global_n, o_local_inhibit_n}, 2'h0);
    chk(o_lb_addr, 32'h0);
    rd(pci_win_pkg::CTL_OFS, 32'h230a_0220);
    rd(pci_win_pkg::XLAT_OFS, 32'h0);
    // first base write turns the image on; low base bits hidden by size 3
    wr(pci_win_pkg::XLAT_OFS, 32'habcd_0000);
    wr(pci_win_pkg::SHELL_OFS, 32'h1);
    wr(pci_win_pkg::BASE_OFS, 32'h1234_0000);
    rd(pci_win_pkg::CTL_OFS, 32'ha30a_0220);
    rd(pci_win_pkg::BASE_OFS, 32'h1230_0000);
    // base is masked as written: narrow to 64 KB, image off, then a later base write
    wr(pci_win_pkg::CTL_OFS, 32'h200a_0220);
    wr(pci_win_pkg::BASE_OFS, 32'h1234_0000);
    rd(pci_win_pkg::CTL_OFS, 32'h200a_0220);
    $display("test reset done");
    // table of decode cases
    for (int k = 0; k < NROW; k++) begin
      wr(pci_win_pkg::CTL_OFS, rows[k].ctl);
      pci(rows[k].addr, rows[k].cmd[2], rows[k].cmd[1]);
      chk(o_pci_claim, rows[k].cmd[0]);
      chk(o_lb_req, rows[k].cmd[0]);
      if (rows[k].cmd[0]) begin
        chk(o_lb_addr, rows[k].xa);
        chk(o_lb_write, rows[k].cmd[2]);
        chk(o_local_bus_xfer_type, rows[k].tt);
        chk(o_lb_prefetch_bytes, rows[k].pf);
        chk(o_lb_byte_order, rows[k].ord);
        chk({o_local_global_n, o_local_inhibit_n, o_lb_shell}, rows[k].att);
      end
    end
    $display("test table done");
    // retention: sequential hit, then a miss discards the kept data
    wr(pci_win_pkg::CTL_OFS, 32'ha00a_02aa);
    pci(32'h1234_4000, 1'h0, 1'h0);
    chk({o_lb_req, o_lb_retained}, 2'h2);
    pci(32'h1234_4004, 1'h0, 1'h0);
    chk({o_pci_claim, o_lb_req, o_lb_retained}, 3'h5);
    pci(32'h1234_5000, 1'h0, 1'h0);
    chk({o_lb_req, o_lb_retained}, 2'h2);
    pci(32'h1234_4008, 1'h0, 1'h0);
    chk({o_lb_req, o_lb_retained}, 2'h2);
    $display("test retain done");
    // shell disabled: hit is retried, nothing forwarded
    wr(pci_win_pkg::SHELL_OFS, 32'h0);
    pci(32'h1234_1000, 1'h0, 1'h1);
    chk({o_pci_retry, o_pci_claim, o_lb_req}, 3'h4);
    wr(pci_win_pkg::SHELL_OFS, 32'h1);
    $display("test retry done");
    // bar enable off: base hidden, frozen, no decode
    wr(pci_win_pkg::CTL_OFS, 32'h800a_0220);
    rd(pci_win_pkg::BASE_OFS, 32'h0);
    wr(pci_win_pkg::BASE_OFS, 32'h5555_0000);
    pci(32'h1234_1000, 1'h0, 1'h1);
    chk(o_pci_claim, 1'h0);
    wr(pci_win_pkg::CTL_OFS, 32'ha00a_0220);
    rd(pci_win_pkg::BASE_OFS, 32'h1234_0000);
    $display("test bar done");
    // zero base clears the image enable
    wr(pci_win_pkg::BASE_OFS, 32'h0);
    rd(pci_win_pkg::CTL_OFS, 32'h200a_0220);
    pci(32'h0000_1000, 1'h0, 1'h1);
    chk(o_pci_claim, 1'h0);
    $display("test image done");
    // unmapped address answers with an error and zero data
    apb(1'h0, 12'h7f0, 32'h0, q, e);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
    $display("test unmapped done");
    // second reset without strap load
    i_eeprom_load <= 1'h0;
    rst();
    rd(pci_win_pkg::CTL_OFS, 32'h000a_0220);
    rd(pci_win_pkg::XLAT_OFS, 32'h0);
    $display("test reset2 done");
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
